// ===== logic/sidm_chan_filter.sv
`timescale 1ns/1ps
`default_nettype none
module sidm_chan_filter (
    input wire logic clock,
    input wire logic reset,
    sidm_filter_if.filt bus
);
    import sidm_pkg::*;
    logic [31:0] hit;
    logic next_accept;
    logic next_drop;
    logic acceptR;
    logic dropR;

    // one comparator per upper channel; bit n guards channel 32+n
    genvar n;
    generate
        for (n = 0; n < 32; n++) begin : g_chan
            assign hit[n] = bus.mask[n] && (bus.pktChan == 6'(32 + n));
        end
    endgenerate

    // lower channels belong to the other mask and are neither taken nor dropped here
    assign next_accept = bus.pktValid && (|hit);
    assign next_drop = bus.pktValid && bus.pktChan[5] && !(|hit);

    always_ff @(posedge clock) begin
        if (reset) begin
            acceptR <= 1'b0;
            dropR <= 1'b0;
        end else begin
            acceptR <= next_accept;
            dropR <= next_drop;
        end
    end
    assign bus.accept = acceptR;
    assign bus.drop = dropR;

    chk_filter_take: assert property (@(posedge clock) disable iff (reset)
        bus.pktValid && bus.pktChan[5] |=> bus.accept == $past(bus.mask[bus.pktChan[4:0]]))
        else $error("upper channel decision does not follow its mask bit");
    chk_filter_lower: assert property (@(posedge clock) disable iff (reset)
        bus.pktValid && !bus.pktChan[5] |=> !bus.accept && !bus.drop)
        else $error("lower channel touched by the upper mask");
    cov_filter_take: cover property (@(posedge clock) disable iff (reset) bus.accept);
endmodule
`default_nettype wire

// ===== logic/sidm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sidm_regs.svh"
// How it works
// - a fault in the latest identify reception sets the fault flag, buffer then undefined.
// - a reception ending without any fault clears the fault flag.
// - internal hardware faults and host memory write faults both count as faults.
// - every bus reset adds one to the 8-bit epoch field, bits 23:16.
// - the epoch field wraps from 255 to zero.
// - bits 10:2 count quadlets written, header quadlet included.
// - the quadlet count returns to zero when a reception starts.
// - bits 30:24, 15:11 and 1:0 of the count register read zero.
// - buffer base is 2 Kbyte aligned; only bits 31:11 are writable.
// - the upper channel mask sits at a set address 0x70 and clear address 0x74.
// - reading either mask address returns the current mask.
// - mask bit n governs isochronous channel 32 plus n.
// - upper channel packets pass only while their mask bit is set.
// - a controller reinit resets these registers but not the bus slave.
module sidm_top (
    input wire logic clock,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire sidm_pkg::sidm_word_t hwdata,
    output sidm_pkg::sidm_word_t hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic busResetSeen,
    input wire logic idRxStart,
    input wire logic idQuadletWritten,
    input wire logic idRxDone,
    input wire logic hwFault,
    input wire logic hostWriteFault,
    input wire logic isoValid,
    input wire sidm_pkg::sidm_chan_t isoChannel,
    output logic isoAccept,
    output logic isoDrop,
    output sidm_pkg::sidm_word_t bufWriteAddr,
    output logic fifoFlush,
    output logic irq
);
    import sidm_pkg::*;

    sidm_bus_state_t state;
    sidm_bus_state_t next_state;
    logic [7:0] addrQ;
    logic [7:0] next_addrQ;
    logic takeReq;
    logic softRst;
    logic regRst;
    logic [31:0] mask;
    logic [31:0] next_mask;
    logic [7:0] epoch;
    logic [8:0] quadCount;
    logic [8:0] next_quadCount;
    logic faultFlag;
    logic errSeen;
    logic anyFault;
    logic [20:0] bufPtr;
    sidm_events_t intStat;
    sidm_events_t intMask;
    sidm_events_t newEvents;
    sidm_events_t next_intStat;
    logic wrCommit;
    logic rdCommit;
    logic wrPtr;
    logic wrSet;
    logic wrClr;
    logic wrIntMask;
    logic wrCtrl;
    logic rdStat;
    sidm_word_t countWord;
    sidm_word_t rdMux;
    sidm_filter_if fbus ();

    // address phase is taken only when the bus is ready and a transfer is active
    assign takeReq = hsel && hready && htrans[1];
    assign wrCommit = (state == SIDM_WDATA);
    assign rdCommit = (state == SIDM_RWAIT);

    // phase sequencing: reads get one wait state so a write just before is seen
    always_comb begin
        next_state = SIDM_IDLE;
        next_addrQ = addrQ;
        if (takeReq) begin
            next_state = hwrite ? SIDM_WDATA : SIDM_RWAIT;
            next_addrQ = haddr[7:0];
        end
        case (state)
            SIDM_IDLE: begin
            end
            SIDM_WDATA: begin
            end
            SIDM_RWAIT: begin
                next_state = SIDM_IDLE; // hready is low here, nothing new taken
            end
            default: begin
                next_state = SIDM_IDLE;
            end
        endcase
    end

    // bus slave state survives a controller reinit, as the host bus side must
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= SIDM_IDLE;
            addrQ <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            state <= next_state;
            addrQ <= next_addrQ;
            hreadyout <= (next_state != SIDM_RWAIT);
            hresp <= 1'b0; // every transfer answers okay
        end
    end

    // write decode against the latched data phase address
    assign wrPtr = wrCommit && (addrQ == `SIDM_OFS_BUF_PTR);
    assign wrSet = wrCommit && (addrQ == `SIDM_OFS_MASK_SET);
    assign wrClr = wrCommit && (addrQ == `SIDM_OFS_MASK_CLR);
    assign wrIntMask = wrCommit && (addrQ == `SIDM_OFS_INT_MASK);
    assign wrCtrl = wrCommit && (addrQ == `SIDM_OFS_CTRL);
    assign rdStat = rdCommit && (addrQ == `SIDM_OFS_INT_STAT);

    // reinit pulse lasts one cycle and restarts everything below the bus slave
    always_ff @(posedge clock) begin
        if (reset) begin
            softRst <= 1'b0;
        end else begin
            softRst <= wrCtrl && hwdata[`SIDM_REINIT_BIT];
        end
    end
    assign regRst = reset || softRst;
    assign fifoFlush = softRst;

    // set and clear in one step; a bit named by both ends cleared
    assign next_mask = (mask | (wrSet ? hwdata : 32'h0)) & ~(wrClr ? hwdata : 32'h0);
    always_ff @(posedge clock) begin
        if (regRst) begin
            mask <= `SIDM_RST_MASK;
        end else begin
            mask <= next_mask;
        end
    end

    // only the upper 21 bits of the base exist, so alignment is built in
    always_ff @(posedge clock) begin
        if (regRst) begin
            bufPtr <= `SIDM_RST_PTR;
        end else if (wrPtr) begin
            bufPtr <= hwdata[31:`SIDM_PTR_LSB];
        end
    end

    // epoch counter wraps naturally on the 8-bit add
    always_ff @(posedge clock) begin
        if (regRst) begin
            epoch <= `SIDM_RST_EPOCH;
        end else if (busResetSeen) begin
            epoch <= epoch + 8'h01;
        end
    end

    // a quadlet in the start cycle is the first of the new reception
    always_comb begin
        next_quadCount = quadCount;
        if (idRxStart) begin
            next_quadCount = `SIDM_RST_QCNT;
        end
        if (idQuadletWritten && next_quadCount != `SIDM_QCNT_MAX) begin
            next_quadCount = next_quadCount + 9'h001;
        end
    end
    always_ff @(posedge clock) begin
        if (regRst) begin
            quadCount <= `SIDM_RST_QCNT;
        end else begin
            quadCount <= next_quadCount;
        end
    end

    // fault flag rises at once and is judged again when the reception ends
    assign anyFault = hwFault || hostWriteFault;
    always_ff @(posedge clock) begin
        if (regRst) begin
            faultFlag <= 1'b0;
            errSeen <= 1'b0;
        end else begin
            if (idRxDone) begin
                faultFlag <= errSeen || anyFault;
            end else if (anyFault) begin
                faultFlag <= 1'b1;
            end
            if (idRxStart) begin
                errSeen <= anyFault;
            end else if (anyFault) begin
                errSeen <= 1'b1;
            end
        end
    end

    // buffer write address follows the base and the quadlets written so far
    always_ff @(posedge clock) begin
        if (regRst) begin
            bufWriteAddr <= 32'h0;
        end else begin
            bufWriteAddr <= {bufPtr, quadCount, 2'b00};
        end
    end

    // reserved ranges are filled with constant zeros
    assign countWord = {faultFlag, 7'h00, epoch, 5'h00, quadCount, 2'b00};

    // events are sticky; a read clears them but a same-cycle event stays
    assign newEvents = {fbus.drop, anyFault, idRxDone, busResetSeen};
    assign next_intStat = (rdStat ? `SIDM_RST_EVENTS : intStat) | newEvents;
    always_ff @(posedge clock) begin
        if (regRst) begin
            intStat <= `SIDM_RST_EVENTS;
            intMask <= `SIDM_RST_EVENTS;
            irq <= 1'b0;
        end else begin
            intStat <= next_intStat;
            irq <= |(next_intStat & (wrIntMask ? hwdata[3:0] : intMask));
            if (wrIntMask) begin
                intMask <= hwdata[3:0];
            end
        end
    end

    // read selection; unmapped offsets read zero
    assign rdMux = (addrQ == `SIDM_OFS_BUF_PTR) ? {bufPtr, 11'h000} :
                   (addrQ == `SIDM_OFS_ID_COUNT) ? countWord :
                   (addrQ == `SIDM_OFS_MASK_SET) ? mask :
                   (addrQ == `SIDM_OFS_MASK_CLR) ? mask :
                   (addrQ == `SIDM_OFS_INT_STAT) ? {28'h0, intStat} :
                   (addrQ == `SIDM_OFS_INT_MASK) ? {28'h0, intMask} : 32'h0;
    always_ff @(posedge clock) begin
        if (reset) begin
            hrdata <= 32'h0;
        end else if (rdCommit) begin
            hrdata <= rdMux;
        end
    end

    // receive path goes through the channel filter
    assign fbus.mask = mask;
    assign fbus.pktValid = isoValid;
    assign fbus.pktChan = isoChannel;
    assign isoAccept = fbus.accept;
    assign isoDrop = fbus.drop;

    sidm_chan_filter u_filter (
        .clock(clock),
        .reset(regRst),
        .bus(fbus.filt)
    );

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    chk_fault_raise: assert property (anyFault && !softRst |=> faultFlag)
        else $error("fault did not raise the flag");
    chk_fault_kinds: assert property (hostWriteFault && !softRst |=> errSeen)
        else $error("host write fault not remembered");
    chk_fault_clean: assert property (
        idRxDone && !errSeen && !anyFault && !softRst |=> !faultFlag)
        else $error("clean reception left the flag set");
    chk_epoch_step: assert property (
        busResetSeen && !softRst |=> epoch == $past(epoch) + 8'h01)
        else $error("epoch did not advance by one");
    chk_epoch_wrap: assert property (
        busResetSeen && !softRst && epoch == 8'hff |=> epoch == 8'h00)
        else $error("epoch did not wrap");
    chk_count_step: assert property (
        idQuadletWritten && !idRxStart && !softRst && quadCount != `SIDM_QCNT_MAX
        |=> quadCount == $past(quadCount) + 9'h001)
        else $error("quadlet count did not advance");
    chk_count_start: assert property (
        idRxStart && !idQuadletWritten && !softRst |=> quadCount == 9'h000)
        else $error("quadlet count not cleared at start");
    chk_count_rsvd: assert property (
        rdCommit && addrQ == `SIDM_OFS_ID_COUNT |=> (hrdata & `SIDM_COUNT_RSVD) == 32'h0)
        else $error("reserved bits of count read nonzero");
    chk_buf_addr: assert property (
        !softRst ##1 !softRst |-> bufWriteAddr == {$past(bufPtr), $past(quadCount), 2'b00})
        else $error("buffer address does not follow base and count");
    chk_mask_set: assert property (
        wrSet && !wrClr && !softRst |=> (mask & $past(hwdata)) == $past(hwdata))
        else $error("written ones did not set mask bits");
    chk_mask_clear: assert property (
        wrClr && !softRst |=> (mask & $past(hwdata)) == 32'h0)
        else $error("written ones did not clear mask bits");
    chk_mask_read: assert property (
        rdCommit && (addrQ == `SIDM_OFS_MASK_SET || addrQ == `SIDM_OFS_MASK_CLR)
        |=> hrdata == $past(mask))
        else $error("mask readback differs");
    chk_reinit_all: assert property (
        softRst |=> mask == `SIDM_RST_MASK && epoch == `SIDM_RST_EPOCH && !faultFlag)
        else $error("reinit left register state");
    chk_read_wait: assert property (takeReq && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    cov_epoch_wrap: cover property (busResetSeen && epoch == 8'hff);
    cov_fault_then_clean: cover property (faultFlag ##[1:50] idRxDone && !errSeen);
    cov_count_read: cover property (rdCommit && addrQ == `SIDM_OFS_ID_COUNT);
    cov_irq: cover property (irq && fbus.drop);
endmodule
`default_nettype wire

// ===== shared/sidm_filter_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sidm_filter_if;
    sidm_pkg::sidm_word_t mask;
    logic pktValid;
    sidm_pkg::sidm_chan_t pktChan;
    logic accept;
    logic drop;
    modport top (output mask, output pktValid, output pktChan, input accept, input drop);
    modport filt (input mask, input pktValid, input pktChan, output accept, output drop);
endinterface
`default_nettype wire

// ===== shared/sidm_pkg.sv
package sidm_pkg;
    typedef logic [31:0] sidm_word_t;
    typedef logic [5:0] sidm_chan_t;
    typedef logic [3:0] sidm_events_t;
    // bus slave phases, one-hot
    typedef enum logic [2:0] {
        SIDM_IDLE = 3'b001,
        SIDM_WDATA = 3'b010,
        SIDM_RWAIT = 3'b100
    } sidm_bus_state_t;
endpackage

// ===== shared/sidm_regs.svh
`ifndef SIDM_REGS_SVH
`define SIDM_REGS_SVH
// byte offsets of the register window
`define SIDM_OFS_BUF_PTR 8'h64
`define SIDM_OFS_ID_COUNT 8'h68
`define SIDM_OFS_MASK_SET 8'h70
`define SIDM_OFS_MASK_CLR 8'h74
`define SIDM_OFS_INT_STAT 8'h90
`define SIDM_OFS_INT_MASK 8'h94
`define SIDM_OFS_CTRL 8'h98
// field positions of the count register
`define SIDM_FAULT_BIT 31
`define SIDM_EPOCH_MSB 23
`define SIDM_EPOCH_LSB 16
`define SIDM_QCNT_MSB 10
`define SIDM_QCNT_LSB 2
`define SIDM_COUNT_RSVD 32'h7f00f803
// buffer base keeps bits 31:11, a 2 Kbyte alignment
`define SIDM_PTR_LSB 11
// control and event bits
`define SIDM_REINIT_BIT 0
`define SIDM_EV_BUS_RESET 0
`define SIDM_EV_ID_DONE 1
`define SIDM_EV_ID_FAULT 2
`define SIDM_EV_ISO_DROP 3
// reset values
`define SIDM_RST_MASK 32'h00000000
`define SIDM_RST_EPOCH 8'h00
`define SIDM_RST_QCNT 9'h000
`define SIDM_RST_PTR 21'h00000
`define SIDM_RST_EVENTS 4'h0
`define SIDM_QCNT_MAX 9'h1ff
`endif

// ===== sim/selfid_count_and_iso_rx_mask_high_bench.sv
`timescale 1ns/1ps
`default_nettype none
module selfid_count_and_iso_rx_mask_high_bench;
    import sidm_pkg::*;
    logic clock = 1'b0;
    logic reset;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    sidm_word_t hwdata;
    sidm_word_t hrdata, bufWriteAddr;
    logic hreadyout, hresp, isoAccept, isoDrop, fifoFlush, irq;
    logic busResetSeen, idRxStart, idQuadletWritten, idRxDone, hwFault, hostWriteFault;
    logic isoValid;
    sidm_chan_t isoChannel;
    logic rdPhase = 1'b0;
    logic isoSeen = 1'b0;
    sidm_word_t expQ[$];
    sidm_word_t isoQ[$];
    sidm_word_t seed = 32'h2f;
    sidm_word_t m = 32'h0;
    sidm_word_t r;
    int numErrors = 0;
    int testsRun = 0;

    always #12.5 clock = ~clock;

    sidm_top uut (
        .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .busResetSeen(busResetSeen), .idRxStart(idRxStart),
        .idQuadletWritten(idQuadletWritten), .idRxDone(idRxDone), .hwFault(hwFault),
        .hostWriteFault(hostWriteFault), .isoValid(isoValid), .isoChannel(isoChannel),
        .isoAccept(isoAccept), .isoDrop(isoDrop), .bufWriteAddr(bufWriteAddr),
        .fifoFlush(fifoFlush), .irq(irq)
    );

    sidm_link_model link (
        .clock(clock), .busResetSeen(busResetSeen), .idRxStart(idRxStart),
        .idQuadletWritten(idQuadletWritten), .idRxDone(idRxDone), .hwFault(hwFault),
        .hostWriteFault(hostWriteFault), .isoValid(isoValid), .isoChannel(isoChannel)
    );

    task automatic chk(input sidm_word_t got, input sidm_word_t exp);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wrapUp();
        $display("checks %0d mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // 32-bit shift register for random mask words
    function automatic sidm_word_t lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // one single AHB transfer; a read notes its expected word for the monitor
    task automatic bus(input logic w, input logic [7:0] a, input sidm_word_t d);
        if (!w) expQ.push_back(d);
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= 2'b10;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        htrans <= 2'b00;
        hwdata <= d;
        rdPhase <= !w;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rdPhase <= 1'b0;
    endtask

    // one identify reception with an optional fault, then the count word read back
    task automatic rx(input int n, input logic [5:0] f, input sidm_word_t e);
        link.ev(6'h02);
        repeat (n) link.ev(6'h04);
        if (f != 6'h00) link.ev(f);
        link.ev(6'h08);
        bus(1'b0, 8'h68, e);
    endtask

    // monitor: read data at the completing edge, iso verdict one edge after the header
    always @(posedge clock) begin
        if (rdPhase && hreadyout === 1'b1) begin
            chk(hrdata, expQ.pop_front());
            chk({31'h0, hresp}, 32'h0);
        end
        if (isoSeen) chk({30'h0, isoAccept, isoDrop}, isoQ.pop_front());
        isoSeen = isoValid;
    end

    // watchdog at 20000 cycles, well beyond the eight hundred or so cycles the sequence needs
    initial begin
        #500000;
        numErrors++;
        wrapUp();
    end

    initial begin
        reset <= 1'b1;
        hsel <= 1'b1;
        haddr <= 32'h0;
        htrans <= 2'b00;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        hwdata <= 32'h0;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        bus(1'b0, 8'h68, 32'h0);
        bus(1'b0, 8'h70, 32'h0);
        bus(1'b1, 8'h68, 32'hffffffff);
        bus(1'b0, 8'h68, 32'h0);
        bus(1'b0, 8'h40, 32'h0);
        // a deselected write must leave the mask untouched
        hsel <= 1'b0;
        bus(1'b1, 8'h70, 32'hffffffff);
        hsel <= 1'b1;
        bus(1'b0, 8'h70, 32'h0);
        $display("test reset done");
        // both end bits first, then random words through set and clear
        r = 32'h80000001;
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 8'h70, r);
            m = m | r;
            bus(1'b0, 8'h74, m);
            r = lfsr();
            bus(1'b1, 8'h74, r);
            m = m & ~r;
            bus(1'b0, 8'h70, m);
            r = lfsr();
        end
        for (int c = 0; c < 64; c++) begin
            isoQ.push_back(c < 32 ? 32'h0 : (m[c[4:0]] ? 32'h2 : 32'h1));
            link.iso(c[5:0]);
        end
        $display("test mask done");
        rx(5, 6'h00, 32'h14);
        rx(3, 6'h10, 32'h8000000c);
        link.ev(6'h02);
        bus(1'b0, 8'h68, 32'h80000000);
        rx(2, 6'h20, 32'h80000008);
        rx(1, 6'h00, 32'h4);
        bus(1'b1, 8'h64, 32'hffffffff);
        bus(1'b0, 8'h64, 32'hfffff800);
        chk(bufWriteAddr, 32'hfffff804);
        $display("test reception done");
        repeat (255) link.ev(6'h01);
        bus(1'b0, 8'h68, 32'h00ff0004);
        link.ev(6'h01);
        bus(1'b0, 8'h68, 32'h4);
        $display("test epoch done");
        bus(1'b1, 8'h98, 32'h1);
        #1 chk({31'h0, fifoFlush}, 32'h1);
        @(posedge clock);
        #1 chk({31'h0, fifoFlush}, 32'h0);
        repeat (2) @(posedge clock);
        bus(1'b0, 8'h68, 32'h0);
        bus(1'b0, 8'h74, 32'h0);
        bus(1'b0, 8'h64, 32'h0);
        $display("test reinit done");
        // unmasked bus reset raises irq, read of status drops it; masked stays low
        bus(1'b1, 8'h94, 32'h1);
        link.ev(6'h01);
        @(posedge clock);
        #1 chk({31'h0, irq}, 32'h1);
        bus(1'b0, 8'h90, 32'h1);
        @(posedge clock);
        #1 chk({31'h0, irq}, 32'h0);
        bus(1'b1, 8'h94, 32'h0);
        link.ev(6'h01);
        @(posedge clock);
        #1 chk({31'h0, irq}, 32'h0);
        bus(1'b0, 8'h90, 32'h1);
        $display("test interrupt done");
        wrapUp();
    end
endmodule
`default_nettype wire

// ===== sim/sidm_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side receive logic: one-cycle event pulses and iso packet headers
module sidm_link_model (
    input wire logic clock,
    output logic busResetSeen,
    output logic idRxStart,
    output logic idQuadletWritten,
    output logic idRxDone,
    output logic hwFault,
    output logic hostWriteFault,
    output logic isoValid,
    output sidm_pkg::sidm_chan_t isoChannel
);
    import sidm_pkg::*;
    // quiet link at time zero
    initial begin
        {hostWriteFault, hwFault, idRxDone, idQuadletWritten, idRxStart, busResetSeen} = 6'h00;
        isoValid = 1'b0;
        isoChannel = 6'h3f;
    end
    // one pulse per call; an idle cycle follows so two calls never merge into one
    task automatic ev(input logic [5:0] e);
        @(posedge clock);
        {hostWriteFault, hwFault, idRxDone, idQuadletWritten, idRxStart, busResetSeen} <= e;
        @(posedge clock);
        {hostWriteFault, hwFault, idRxDone, idQuadletWritten, idRxStart, busResetSeen} <= 6'h00;
    endtask
    // header for one cycle; the stale channel is inverted so it cannot pass for valid
    task automatic iso(input sidm_chan_t ch);
        @(posedge clock);
        isoValid <= 1'b1;
        isoChannel <= ch;
        @(posedge clock);
        isoValid <= 1'b0;
        isoChannel <= ~ch;
    endtask
endmodule
`default_nettype wire
